// [hdl/ihw_device.sv]
`timescale 1ns/100ps
`include "ihw_map.svh"
module ihw_device #(
	parameter int IDLE_CYCLES = `IHW_IDLE_CYCLES,
	parameter int IDLE_W = 23,
	parameter logic [6:0] DEV_ADDR = `IHW_DEV_ADDR
) (
	input wire logic oscClk,
	input wire logic resetn,
	ihw_if.dev bus,
	output logic oscRun,
	output logic wrStrobe,
	output logic [7:0] wrAddr,
	output logic [7:0] wrData,
	output logic [7:0] rdAddr,
	input wire logic [7:0] rdData,
	input wire logic keyEvent,
	input wire logic irqReq,
	input wire logic busy,
	input wire logic [IDLE_W-1:0] idlePeriod
);
	import ihw_pkg::*;

	typedef struct packed {
		ihw_dev_st_t st;
		logic sclQ;
		logic sdaQ;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] regPtr;
		logic regDone;
		logic isRead;
		logic wakeNack;
		logic hold;
		logic sclOe;
		logic sdaOe;
		logic intN;
		logic run;
		logic wrStb;
		logic [7:0] wrAddr;
		logic [7:0] wrData;
		logic [IDLE_W-1:0] idleCnt;
	} ihw_dev_reg_t;

	localparam ihw_dev_reg_t RST = '{
		st: DS_IDLE,
		sclQ: 1'h1,
		sdaQ: 1'h1,
		bitCnt: 4'h0,
		shift: 8'h00,
		regPtr: 8'h00,
		regDone: 1'h0,
		isRead: 1'h0,
		wakeNack: 1'h0,
		hold: 1'h0,
		sclOe: 1'h0,
		sdaOe: 1'h0,
		intN: 1'h1,
		run: 1'h1,
		wrStb: 1'h0,
		wrAddr: 8'h00,
		wrData: 8'h00,
		idleCnt: '0
	};

	generate
		if (IDLE_W < 2 || IDLE_W > 30 || IDLE_CYCLES < 2 || IDLE_CYCLES >= (1 << IDLE_W)) begin : g_chk
			$error("ihw_device idle counter cannot hold IDLE_CYCLES");
		end
	endgenerate

	ihw_dev_reg_t s;
	ihw_dev_reg_t next_s;
	logic [1:0] pinQ;
	logic sclNow;
	logic sdaNow;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic addrMatch;
	logic [IDLE_W-1:0] idleLimit;

	// the oscillator clock is asynchronous to the bus pins
	ihw_sync #(.W(2)) u_pin_sync (
		.clk(oscClk),
		.resetn(resetn),
		.d({bus.scl, bus.sda}),
		.q(pinQ)
	);

	assign sclNow = pinQ[1];
	assign sdaNow = pinQ[0];
	assign sclRise = sclNow && !s.sclQ;
	assign sclFall = !sclNow && s.sclQ;
	assign startSeen = sclNow && s.sclQ && s.sdaQ && !sdaNow;
	assign stopSeen = sclNow && s.sclQ && !s.sdaQ && sdaNow;
	assign addrMatch = (s.shift[7:1] == DEV_ADDR);
	// zero selects the power-on period; entry itself cannot be disabled
	assign idleLimit = (idlePeriod == '0) ? IDLE_W'(IDLE_CYCLES) : idlePeriod;

	always_comb begin
		next_s = s;
		next_s.sclQ = sclNow;
		next_s.sdaQ = sdaNow;
		next_s.wrStb = 1'h0;
		next_s.intN = !irqReq;
		if (!busy) begin
			next_s.hold = 1'h0;
		end

		if (s.st != DS_HALT && startSeen) begin
			// repeated start keeps pointer and index state
			next_s.st = DS_ADDR;
			next_s.bitCnt = 4'h0;
			next_s.sdaOe = 1'h0;
			next_s.hold = 1'h0;
		end else if (s.st != DS_HALT && stopSeen) begin
			next_s.st = DS_IDLE;
			next_s.regDone = 1'h0;
			next_s.sdaOe = 1'h0;
			next_s.hold = 1'h0;
		end else begin
			case (s.st)
				DS_HALT: begin
					// the address after the waking start cannot be acknowledged
					if (startSeen) begin
						next_s.st = DS_ADDR;
						next_s.bitCnt = 4'h0;
						next_s.wakeNack = 1'h1;
					end else if (keyEvent) begin
						next_s.st = DS_IDLE;
					end
				end
				DS_IDLE, DS_WAIT: begin
				end
				DS_ADDR: begin
					if (sclRise) begin
						next_s.shift = {s.shift[6:0], sdaNow};
						next_s.bitCnt = s.bitCnt + 4'h1;
					end else if (sclFall && s.bitCnt == `IHW_ACK_SLOT) begin
						if (!addrMatch) begin
							// a foreign address after wake-up sends us back to halt
							next_s.st = s.wakeNack ? DS_HALT : DS_WAIT;
							next_s.wakeNack = 1'h0;
						end else if (s.wakeNack) begin
							next_s.st = DS_WAIT;
							next_s.wakeNack = 1'h0;
							next_s.idleCnt = '0;
						end else begin
							next_s.st = DS_ACK;
							next_s.sdaOe = 1'h1;
							next_s.isRead = (s.shift[0] == `IHW_RW_READ);
						end
					end
				end
				DS_ACK: begin
					if (sclFall) begin
						next_s.sdaOe = 1'h0;
						next_s.hold = busy;
						next_s.bitCnt = 4'h0;
						if (s.isRead) begin
							next_s.st = DS_TX;
							next_s.shift = rdData;
							next_s.sdaOe = !rdData[7];
						end else begin
							next_s.st = DS_RX;
						end
					end
				end
				DS_RX: begin
					if (sclRise) begin
						next_s.shift = {s.shift[6:0], sdaNow};
						next_s.bitCnt = s.bitCnt + 4'h1;
					end else if (sclFall && s.bitCnt == `IHW_ACK_SLOT) begin
						if (s.regDone) begin
							next_s.wrStb = 1'h1;
							next_s.wrAddr = s.regPtr;
							next_s.wrData = s.shift;
							next_s.regPtr = s.regPtr + `IHW_PTR_STEP;
						end else begin
							next_s.regPtr = s.shift;
							next_s.regDone = 1'h1;
						end
						next_s.st = DS_ACK;
						next_s.isRead = 1'h0;
						next_s.sdaOe = 1'h1;
					end
				end
				DS_TX: begin
					if (sclRise) begin
						next_s.shift = {s.shift[6:0], sdaNow};
						next_s.bitCnt = s.bitCnt + 4'h1;
					end else if (sclFall) begin
						if (s.bitCnt == `IHW_ACK_SLOT) begin
							next_s.sdaOe = 1'h0;
							next_s.st = DS_MACK;
						end else begin
							next_s.sdaOe = !s.shift[7];
						end
					end
				end
				DS_MACK: begin
					if (sclRise) begin
						next_s.regPtr = s.regPtr + `IHW_PTR_STEP;
						if (sdaNow) begin
							next_s.st = DS_WAIT;
						end else begin
							next_s.bitCnt = `IHW_RX_MARK;
						end
					end else if (sclFall && s.bitCnt == `IHW_RX_MARK) begin
						// rdAddr already shows the new pointer here
						next_s.st = DS_TX;
						next_s.bitCnt = 4'h0;
						next_s.shift = rdData;
						next_s.sdaOe = !rdData[7];
						next_s.hold = busy;
					end
				end
				default: begin
					next_s = RST;
				end
			endcase
		end

		// only own traffic and keys restart the count; foreign traffic is idle time once its address byte is over
		if (keyEvent || s.st == DS_ACK || s.st == DS_RX || s.st == DS_TX || s.st == DS_MACK) begin
			next_s.idleCnt = '0;
		end else if (s.st == DS_IDLE || s.st == DS_WAIT) begin
			next_s.idleCnt = s.idleCnt + IDLE_W'(1);
		end
		if ((next_s.st == DS_IDLE || next_s.st == DS_WAIT) && s.idleCnt >= idleLimit - IDLE_W'(1)) begin
			next_s.st = DS_HALT;
			next_s.idleCnt = '0;
			next_s.sdaOe = 1'h0;
			next_s.hold = 1'h0;
			next_s.regDone = 1'h0;
		end
		// hold SCL low only while it is already low, never pull it mid-high
		next_s.sclOe = next_s.hold && (!sclNow || s.sclOe);
		next_s.run = (next_s.st != DS_HALT);
	end

	always_ff @(posedge oscClk) begin
		if (!resetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign bus.devSclOut = 1'h0;
	assign bus.devSdaOut = 1'h0;
	assign bus.devSclOe = s.sclOe;
	assign bus.devSdaOe = s.sdaOe;
	assign bus.intN = s.intN;
	assign oscRun = s.run;
	assign wrStrobe = s.wrStb;
	assign wrAddr = s.wrAddr;
	assign wrData = s.wrData;
	assign rdAddr = s.regPtr;
endmodule

// [hdl/ihw_map.svh]
`ifndef IHW_MAP_SVH
`define IHW_MAP_SVH

`define IHW_DEV_ADDR 7'h44
`define IHW_RW_WRITE 1'h0
`define IHW_RW_READ 1'h1
`define IHW_ACK_SLOT 4'h8
`define IHW_RX_MARK 4'h9
`define IHW_PTR_STEP 8'h01
`define IHW_OSC_PERIOD_NS 160
`define IHW_IDLE_MS 1020
`define IHW_IDLE_CYCLES ((`IHW_IDLE_MS * 1000000) / `IHW_OSC_PERIOD_NS)
`define IHW_CLK_PERIOD_NS 10
`define IHW_SCL_KHZ_STD 100
`define IHW_SCL_KHZ_FAST 400
`define IHW_HALF_NS_NUM 1000000

`endif

// [hdl/ihw_pkg.sv]
package ihw_pkg;

	typedef enum logic [7:0] {
		DS_HALT = 8'h01,
		DS_IDLE = 8'h02,
		DS_ADDR = 8'h04,
		DS_ACK = 8'h08,
		DS_RX = 8'h10,
		DS_TX = 8'h20,
		DS_MACK = 8'h40,
		DS_WAIT = 8'h80
	} ihw_dev_st_t;

	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_START = 4'h2,
		HS_BIT = 4'h4,
		HS_STOP = 4'h8
	} ihw_host_st_t;

	typedef enum logic [2:0] {
		SP_ADDRW = 3'h0,
		SP_REG = 3'h1,
		SP_DATA = 3'h2,
		SP_ADDRR = 3'h3,
		SP_RX = 3'h4
	} ihw_step_t;

endpackage

// [hdl/ihw_if.sv]
`timescale 1ns/100ps
interface ihw_if;
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSclOut;
	logic devSclOe;
	logic devSdaOut;
	logic devSdaOe;
	logic intN;
	logic scl;
	logic sda;

	// wired-and of both open-drain drivers, pull-up when nobody drives
	assign scl = (hostSclOe ? hostSclOut : 1'h1) & (devSclOe ? devSclOut : 1'h1);
	assign sda = (hostSdaOe ? hostSdaOut : 1'h1) & (devSdaOe ? devSdaOut : 1'h1);

	modport dev (
		input scl,
		input sda,
		output devSclOut,
		output devSclOe,
		output devSdaOut,
		output devSdaOe,
		output intN
	);

	modport host (
		input scl,
		input sda,
		input intN,
		output hostSclOut,
		output hostSclOe,
		output hostSdaOut,
		output hostSdaOe
	);
endinterface

// [hdl/ihw_sync.sv]
`timescale 1ns/100ps
module ihw_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} ihw_sync_reg_t;

	ihw_sync_reg_t s;
	ihw_sync_reg_t next_s;

	generate
		if (W < 1) begin : g_chk
			$error("ihw_sync width must be positive");
		end
	endgenerate

	// idle bus lines are high, so the chain resets to ones
	always_comb begin
		next_s.meta = d;
		next_s.q = s.meta;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;
endmodule

// [hdl/ihw_host.sv]
`timescale 1ns/100ps
`include "ihw_map.svh"
module ihw_host #(
	parameter int SCL_KHZ = `IHW_SCL_KHZ_FAST,
	parameter logic [6:0] DEV_ADDR = `IHW_DEV_ADDR
) (
	input wire logic clk,
	input wire logic resetn,
	ihw_if.host bus,
	input wire logic reqValid,
	input wire logic reqRead,
	input wire logic [7:0] reqReg,
	input wire logic [7:0] reqData,
	output logic reqReady,
	output logic doneValid,
	output logic [7:0] doneData,
	output logic doneNack,
	output logic irqPending
);
	import ihw_pkg::*;

	localparam int DIV = 2 * SCL_KHZ * `IHW_CLK_PERIOD_NS;
	localparam int HALF = (`IHW_HALF_NS_NUM + DIV - 1) / DIV;

	typedef struct packed {
		ihw_host_st_t st;
		ihw_step_t step;
		logic [1:0] ph;
		logic [9:0] timer;
		logic [3:0] bitIdx;
		logic [7:0] rxShift;
		logic tried;
		logic retryPend;
		logic fail;
		logic rd;
		logic [7:0] regIdx;
		logic [7:0] data;
		logic sclOe;
		logic sdaOe;
		logic ready;
		logic doneV;
		logic [7:0] doneD;
		logic doneN;
		logic irq;
	} ihw_host_reg_t;

	localparam ihw_host_reg_t RST = '{
		st: HS_IDLE,
		step: SP_ADDRW,
		ph: 2'h0,
		timer: 10'h000,
		bitIdx: 4'h0,
		rxShift: 8'h00,
		tried: 1'h0,
		retryPend: 1'h0,
		fail: 1'h0,
		rd: 1'h0,
		regIdx: 8'h00,
		data: 8'h00,
		sclOe: 1'h0,
		sdaOe: 1'h0,
		ready: 1'h1,
		doneV: 1'h0,
		doneD: 8'h00,
		doneN: 1'h0,
		irq: 1'h0
	};

	generate
		if ((SCL_KHZ != `IHW_SCL_KHZ_STD && SCL_KHZ != `IHW_SCL_KHZ_FAST) || HALF >= 1024) begin : g_chk
			$error("ihw_host supports only the two standard bus rates");
		end
	endgenerate

	function automatic logic [7:0] txByteFor(ihw_step_t st, logic [7:0] r, logic [7:0] d);
		case (st)
			SP_ADDRW: txByteFor = {DEV_ADDR, `IHW_RW_WRITE};
			SP_REG: txByteFor = r;
			SP_DATA: txByteFor = d;
			SP_ADDRR: txByteFor = {DEV_ADDR, `IHW_RW_READ};
			default: txByteFor = 8'hFF;
		endcase
	endfunction

	ihw_host_reg_t s;
	ihw_host_reg_t next_s;
	logic [2:0] pinQ;
	logic halfDone;
	logic bitVal;
	logic [7:0] txByte;

	ihw_sync #(.W(3)) u_pin_sync (
		.clk(clk),
		.resetn(resetn),
		.d({bus.scl, bus.sda, bus.intN}),
		.q(pinQ)
	);

	assign halfDone = (s.timer == 10'(HALF - 1));
	assign txByte = txByteFor(s.step, s.regIdx, s.data);
	// a read byte and every ack slot leave SDA released; the final read ack stays high as NACK
	assign bitVal = (s.step != SP_RX && s.bitIdx < `IHW_ACK_SLOT) ? txByte[3'(4'h7 - s.bitIdx)] : 1'h1;

	always_comb begin
		next_s = s;
		next_s.doneV = 1'h0;
		next_s.irq = !pinQ[0];
		next_s.timer = halfDone ? 10'h000 : s.timer + 10'h001;
		// a high phase only starts counting once the line really is high
		if (s.ph == 2'h1 && !pinQ[2]) begin
			next_s.timer = 10'h000;
		end
		case (s.st)
			HS_IDLE: begin
				next_s.timer = 10'h000;
				if (reqValid && s.ready) begin
					next_s.ready = 1'h0;
					next_s.rd = reqRead;
					next_s.regIdx = reqReg;
					next_s.data = reqData;
					next_s.tried = 1'h0;
					next_s.fail = 1'h0;
					next_s.st = HS_START;
					next_s.step = SP_ADDRW;
					next_s.ph = 2'h0;
				end
			end
			HS_START: begin
				next_s.sclOe = (s.ph == 2'h0) || (s.ph == 2'h2 && halfDone);
				next_s.sdaOe = (s.ph == 2'h2);
				if (halfDone) begin
					next_s.ph = (s.ph == 2'h2) ? 2'h0 : s.ph + 2'h1;
					if (s.ph == 2'h2) begin
						next_s.st = HS_BIT;
						next_s.bitIdx = 4'h0;
					end
				end
			end
			HS_BIT: begin
				if (s.ph == 2'h0) begin
					next_s.sclOe = !halfDone;
					next_s.sdaOe = !bitVal;
					if (halfDone) begin
						next_s.ph = 2'h1;
					end
				end else if (halfDone) begin
					next_s.sclOe = 1'h1;
					next_s.ph = 2'h0;
					next_s.bitIdx = s.bitIdx + 4'h1;
					if (s.bitIdx < `IHW_ACK_SLOT) begin
						next_s.rxShift = {s.rxShift[6:0], pinQ[1]};
					end else begin
						next_s.bitIdx = 4'h0;
						next_s.st = HS_STOP;
						case (s.step)
							SP_ADDRW: begin
								if (!pinQ[1]) begin
									next_s.st = HS_BIT;
									next_s.step = SP_REG;
								end else if (!s.tried) begin
									next_s.tried = 1'h1;
									next_s.retryPend = 1'h1;
								end else begin
									next_s.fail = 1'h1;
								end
							end
							SP_REG: begin
								next_s.fail = pinQ[1];
								if (!pinQ[1]) begin
									// chain with repeated start, not stop and start
									next_s.st = s.rd ? HS_START : HS_BIT;
									next_s.step = s.rd ? SP_ADDRR : SP_DATA;
								end
							end
							SP_ADDRR: begin
								next_s.fail = pinQ[1];
								if (!pinQ[1]) begin
									next_s.st = HS_BIT;
									next_s.step = SP_RX;
								end
							end
							SP_DATA: begin
								next_s.fail = pinQ[1];
							end
							default: begin
							end
						endcase
					end
				end
			end
			HS_STOP: begin
				next_s.sclOe = (s.ph == 2'h0);
				next_s.sdaOe = (s.ph != 2'h2);
				if (halfDone) begin
					next_s.ph = (s.ph == 2'h2) ? 2'h0 : s.ph + 2'h1;
					if (s.ph == 2'h2) begin
						if (s.retryPend) begin
							next_s.retryPend = 1'h0;
							next_s.st = HS_START;
							next_s.step = SP_ADDRW;
						end else begin
							next_s.st = HS_IDLE;
							next_s.ready = 1'h1;
							next_s.doneV = 1'h1;
							next_s.doneD = s.rxShift;
							next_s.doneN = s.fail;
						end
					end
				end
			end
			default: begin
				next_s = RST;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign bus.hostSclOut = 1'h0;
	assign bus.hostSdaOut = 1'h0;
	assign bus.hostSclOe = s.sclOe;
	assign bus.hostSdaOe = s.sdaOe;
	assign reqReady = s.ready;
	assign doneValid = s.doneV;
	assign doneData = s.doneD;
	assign doneNack = s.doneN;
	assign irqPending = s.irq;
endmodule

// [test/ihw_properties.sv]
`timescale 1ns/100ps
module ihw_properties (
	input wire logic oscClk,
	input wire logic resetn,
	input wire logic hostSclOut,
	input wire logic hostSclOe,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic devSclOut,
	input wire logic devSclOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic intN,
	input wire logic scl,
	input wire logic sda
);
	typedef struct packed {
		logic sclQ;
		logic sdaQ;
		logic inAddr;
		logic [3:0] bits;
	} ihw_mon_t;
	ihw_mon_t mon;
	ihw_mon_t next_mon;

	// bit position since the last start, so the address byte can be told from the rest
	always_comb begin
		next_mon = mon;
		next_mon.sclQ = scl;
		next_mon.sdaQ = sda;
		if (mon.sclQ && scl && mon.sdaQ && !sda) begin
			next_mon.inAddr = 1'h1;
			next_mon.bits = 4'h0;
		end else if (!mon.sclQ && scl) begin
			next_mon.inAddr = mon.inAddr && (mon.bits != 4'h8);
			next_mon.bits = (mon.bits == 4'h8) ? 4'h0 : mon.bits + 4'h1;
		end
	end

	always_ff @(posedge oscClk) begin
		if (!resetn) begin
			// idle lines are high; copies reset low would fake a rising edge
			mon <= '{sclQ: 1'h1, sdaQ: 1'h1, inAddr: 1'h0, bits: 4'h0};
		end else begin
			mon <= next_mon;
		end
	end

	default clocking @(posedge oscClk); endclocking
	default disable iff (!resetn);

	open_drain_a: assert property (!(hostSclOut || hostSdaOut || devSclOut || devSdaOut))
		else $error("open-drain output driven high");
	sda_in_low_a: assert property ($changed(devSdaOe) |-> !scl)
		else $error("device changed data while clock high");
	sync_lag_a: assert property ($changed(devSdaOe) |-> !$past(scl) && !$past(scl, 2))
		else $error("device data changed too soon after clock fall");
	no_start_a: assert property ($fell(sda) && scl && $past(scl) |-> hostSdaOe && !devSdaOe)
		else $error("start condition not made by the host");
	stretch_low_a: assert property ($rose(devSclOe) |-> !$past(scl))
		else $error("device pulled a high clock low");
	stretch_ends_a: assert property ($rose(devSclOe) |-> ##[1:100] !devSclOe)
		else $error("clock stretch not released in time");
	addr_quiet_a: assert property (mon.inAddr && mon.bits < 4'h8 |-> !devSdaOe)
		else $error("device drove data during address bits");
	stop_quiet_a: assert property ($rose(sda) && scl && $past(scl) |=> !devSdaOe [*8])
		else $error("device drove data right after stop");
	int_steady_a: assert property ($changed(intN) |=> $stable(intN))
		else $error("interrupt line glitched for one cycle");
endmodule

// [test/i2c_slave_halt_wake_test.sv]
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
	$display("MISMATCH time=%0t got=%h exp=%h", $time, (got), (exp)); end end
module i2c_slave_halt_wake_test;
	logic clk, oscClk, resetn, reqValid, reqValidB, reqRead, reqReady, reqReadyB, doneValid, doneValidB;
	logic doneNack, doneNackB, irqPending, oscRunA, oscRunB, wrStrobe, keyEvent, irqReq, busy;
	logic sclQ, sdaQ, doneNackQ;
	logic [7:0] reqReg, reqData, doneData, wrAddr, wrData, rdAddr, rdData, lastAddr, lastData;
	logic [7:0] firstByte, shiftA, doneDataQ;
	logic [22:0] idlePeriod;
	int failures, cmp_count, startCount, bitIdx, cycles;
	ihw_if linkA();
	// second link: a host with another address, so its traffic is foreign to the device there
	ihw_if linkB();
	assign rdData = rdAddr ^ 8'h3C;

	ihw_device #(.IDLE_CYCLES(200)) u_ihw_device (.oscClk(oscClk), .resetn(resetn), .bus(linkA),
		.oscRun(oscRunA), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr),
		.rdData(rdData), .keyEvent(keyEvent), .irqReq(irqReq), .busy(busy), .idlePeriod(idlePeriod));
	ihw_device #(.IDLE_CYCLES(200)) u_ihw_device_far (.oscClk(oscClk), .resetn(resetn), .bus(linkB),
		.oscRun(oscRunB), .wrStrobe(), .wrAddr(), .wrData(), .rdAddr(), .rdData(rdData),
		.keyEvent(keyEvent), .irqReq(irqReq), .busy(busy), .idlePeriod(idlePeriod));
	ihw_host u_ihw_host (.clk(clk), .resetn(resetn), .bus(linkA), .reqValid(reqValid), .reqRead(reqRead),
		.reqReg(reqReg), .reqData(reqData), .reqReady(reqReady), .doneValid(doneValid),
		.doneData(doneData), .doneNack(doneNack), .irqPending(irqPending));
	ihw_host #(.DEV_ADDR(7'h21)) u_ihw_host_far (.clk(clk), .resetn(resetn), .bus(linkB),
		.reqValid(reqValidB), .reqRead(reqRead), .reqReg(reqReg), .reqData(reqData), .reqReady(reqReadyB),
		.doneValid(doneValidB), .doneData(), .doneNack(doneNackB), .irqPending());
	ihw_properties u_ihw_properties (.oscClk(oscClk), .resetn(resetn), .hostSclOut(linkA.hostSclOut),
		.hostSclOe(linkA.hostSclOe), .hostSdaOut(linkA.hostSdaOut), .hostSdaOe(linkA.hostSdaOe),
		.devSclOut(linkA.devSclOut), .devSclOe(linkA.devSclOe), .devSdaOut(linkA.devSdaOut),
		.devSdaOe(linkA.devSdaOe), .intN(linkA.intN), .scl(linkA.scl), .sda(linkA.sda));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		oscClk = 1'h0;
		#3;
		forever #80 oscClk = ~oscClk;
	end

	// wire watcher: counts starts and keeps the first byte after the latest one
	always @(posedge clk) begin
		if (sclQ && linkA.scl && sdaQ && !linkA.sda) begin
			startCount++;
			bitIdx = 0;
		end else if (!sclQ && linkA.scl) begin
			shiftA = {shiftA[6:0], linkA.sda};
			bitIdx++;
			if (bitIdx == 8) begin
				firstByte = shiftA;
			end
		end
		sclQ = linkA.scl;
		sdaQ = linkA.sda;
	end
	always @(posedge oscClk) begin
		if (wrStrobe === 1'h1) begin
			lastAddr = wrAddr;
			lastData = wrData;
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic hostReq(input bit useB, input logic rd, input logic [7:0] r, input logic [7:0] d);
		int n;
		@(posedge clk) #1;
		reqRead = rd;
		reqReg = r;
		reqData = d;
		reqValid = !useB;
		reqValidB = useB;
		@(posedge clk);
		while ((useB ? reqReadyB : reqReady) !== 1'h1) @(posedge clk);
		#1 reqValid = 1'h0;
		reqValidB = 1'h0;
		for (n = 0; n < 40000 && (useB ? doneValidB : doneValid) !== 1'h1; n++) @(posedge clk);
		// a lost answer counts as a mismatch
		if (n == 40000) begin
			failures++;
		end
		doneNackQ = useB ? doneNackB : doneNack;
		doneDataQ = doneData;
	endtask

	task automatic test_write();
		hostReq(0, 1'h0, 8'hAA, 8'h5C);
		`CHECK_EQ(doneNackQ, 1'h0)
		`CHECK_EQ(firstByte, 8'h88)
		`CHECK_EQ(lastAddr, 8'hAA)
		`CHECK_EQ(lastData, 8'h5C)
		`CHECK_EQ(rdAddr, 8'hAB)
		$display("test write finished");
	endtask

	task automatic test_read();
		int s0;
		s0 = startCount;
		hostReq(0, 1'h1, 8'h37, 8'h00);
		`CHECK_EQ(doneNackQ, 1'h0)
		`CHECK_EQ(doneDataQ, 8'h37 ^ 8'h3C)
		`CHECK_EQ(firstByte, 8'h89)
		`CHECK_EQ(startCount - s0, 2)
		$display("test read finished");
	endtask

	task automatic test_irq();
		int n;
		@(posedge oscClk) #1 irqReq = 1'h1;
		for (n = 0; n < 80 && irqPending !== 1'h1; n++) @(posedge clk);
		`CHECK_EQ(linkA.intN, 1'h0)
		`CHECK_EQ(irqPending, 1'h1)
		@(posedge oscClk) #1 irqReq = 1'h0;
		for (n = 0; n < 80 && irqPending !== 1'h0; n++) @(posedge clk);
		`CHECK_EQ(linkA.intN, 1'h1)
		`CHECK_EQ(irqPending, 1'h0)
		$display("test irq finished");
	endtask

	task automatic test_busy();
		int n;
		logic saw;
		@(posedge oscClk) #1 busy = 1'h1;
		fork
			hostReq(0, 1'h0, 8'h10, 8'hE7);
			begin
				for (n = 0; n < 20000 && linkA.devSclOe !== 1'h1; n++) @(posedge clk);
				saw = linkA.devSclOe;
				repeat (40) @(posedge oscClk);
				#1 busy = 1'h0;
			end
		join
		`CHECK_EQ(saw, 1'h1)
		`CHECK_EQ(doneNackQ, 1'h0)
		`CHECK_EQ(lastData, 8'hE7)
		$display("test busy finished");
	endtask

	task automatic test_halt();
		int n;
		int s0;
		@(posedge oscClk) #1 idlePeriod = 23'h0;
		// key events closer than the idle limit must keep the oscillator running
		repeat (5) begin
			repeat (150) @(posedge oscClk);
			#1 keyEvent = 1'h1;
			@(posedge oscClk) #1 keyEvent = 1'h0;
			`CHECK_EQ(oscRunA, 1'h1)
		end
		for (n = 0; n < 300 && oscRunA !== 1'h0; n++) @(posedge oscClk);
		`CHECK_EQ(n > 150, 1'h1)
		`CHECK_EQ(oscRunA, 1'h0)
		s0 = startCount;
		hostReq(0, 1'h0, 8'h21, 8'h9D);
		`CHECK_EQ(startCount - s0, 2)
		`CHECK_EQ(doneNackQ, 1'h0)
		`CHECK_EQ(lastData, 8'h9D)
		`CHECK_EQ(oscRunA, 1'h1)
		$display("test halt finished");
	endtask

	task automatic test_foreign();
		int n;
		logic sawHalt;
		logic sawWake;
		@(posedge oscClk) #1 keyEvent = 1'h1;
		@(posedge oscClk) #1 keyEvent = 1'h0;
		for (n = 0; n < 20 && oscRunB !== 1'h1; n++) @(posedge oscClk);
		`CHECK_EQ(oscRunB, 1'h1)
		fork
			repeat (2) hostReq(1, 1'h0, 8'h05, 8'h66);
			begin
				for (n = 0; n < 800 && oscRunB !== 1'h0; n++) @(posedge oscClk);
				sawHalt = (n < 800);
			end
		join
		`CHECK_EQ(sawHalt, 1'h1)
		// a foreign start wakes the halted device, which then drops back to halt
		fork
			hostReq(1, 1'h0, 8'h05, 8'h66);
			begin
				for (n = 0; n < 400 && oscRunB !== 1'h1; n++) @(posedge oscClk);
				sawWake = (n < 400);
			end
		join
		`CHECK_EQ(sawWake, 1'h1)
		`CHECK_EQ(doneNackQ, 1'h1)
		for (n = 0; n < 300 && oscRunB !== 1'h0; n++) @(posedge oscClk);
		`CHECK_EQ(oscRunB, 1'h0)
		$display("test foreign finished");
	endtask

	initial begin
		{reqValid, reqValidB, reqRead, keyEvent, irqReq, busy, resetn} = 7'h0;
		{reqReg, reqData} = 16'h0;
		{sclQ, sdaQ} = 2'h3;
		idlePeriod = 23'h1388;
		repeat (10) @(posedge oscClk);
		#1 resetn = 1'h1;
		test_write();
		test_read();
		test_irq();
		test_busy();
		test_halt();
		test_foreign();
		print_verdict();
	end
endmodule
